/* File: logic/alr_map.svh */
`ifndef ALR_MAP_SVH
`define ALR_MAP_SVH

// ---------------------------------------------------------------
// Readback port addresses
// ---------------------------------------------------------------
`define ALR_PORT_INTC        16'h0020
`define ALR_PORT_TIMER       16'h0040
`define ALR_PORT_TIMER_TWO   16'h0042
`define ALR_PORT_RTC_INDEX   16'h0070

// ---------------------------------------------------------------
// Sequence lengths, as last zero-based position, and words per controller as a count
// ---------------------------------------------------------------
`define ALR_INTC_LAST        4'hB
`define ALR_TIMER_LAST       4'h6
`define ALR_INTC_WORDS       6

// ---------------------------------------------------------------
// Reserved-bit handling of controller, timer status and RTC index words
// ---------------------------------------------------------------
`define ALR_INIT_TWO_KEEP    8'hF8
`define ALR_INIT_FOUR_KEEP   8'h12
`define ALR_EOI_KEEP         8'hE7
`define ALR_POLL_FORCED      2'h1
`define ALR_STATUS_KEEP      8'h3F
`define ALR_RTC_KEEP         8'h7F

// ---------------------------------------------------------------
// System tick timing
// ---------------------------------------------------------------
`define ALR_CLOCK_MHZ        250
`define ALR_TICK_FAST_US     13500
`define ALR_TICK_SLOW_US     54600
`define ALR_TICK_W           24

`endif

/* File: logic/alr_pkg.sv */
package alr_pkg;

  // Port selected by an I/O address
  typedef enum logic [2:0] {
    ALR_NONE,
    ALR_INTC,
    ALR_TIMER,
    ALR_TIMER_TWO,
    ALR_RTC
  } alr_port_t;

  typedef logic [3:0] alr_ptr_t;

endpackage

/* File: logic/alr_readback.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alr_map.svh"

module alr_readback #(
  parameter int TICK_FAST_CYCLES = `ALR_TICK_FAST_US * `ALR_CLOCK_MHZ,
  parameter int TICK_SLOW_CYCLES = `ALR_TICK_SLOW_US * `ALR_CLOCK_MHZ
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // Mode select
  input  wire logic                  alternate_access_mode,
  // Byte I/O port access
  input  wire logic [15:0]           io_addr,
  input  wire logic                  io_rd,
  input  wire logic                  io_wr,
  input  wire logic [7:0]            io_wdata,
  output var  logic [7:0]            io_rdata,
  output var  logic                  io_rdata_valid,
  // Restore path to legacy blocks
  output var  logic                  restore_wr,
  output var  logic [7:0]            restore_port,
  output var  logic [7:0]            restore_data,
  // Legacy state, [ctl][word]: init 2,3,4, mask, eoi, poll
  input  wire logic [1:0][5:0][7:0]  intc_words,
  input  wire logic [7:0]            timer_zero_status,
  input  wire logic [15:0]           timer_zero_base,
  input  wire logic [7:0]            timer_two_status,
  input  wire logic [15:0]           timer_two_base,
  input  wire logic [6:0]            rtc_index,
  // System tick
  output var  logic                  timer_fast,
  output var  logic                  sys_tick
);

  localparam int TW = `ALR_TICK_W;

  // ---------------------------------------------------------------
  // Decode and reserved-bit functions
  // ---------------------------------------------------------------
  function automatic alr_pkg::alr_port_t port_of(input logic [15:0] a);
    case (a)
      `ALR_PORT_INTC:      port_of = alr_pkg::ALR_INTC;
      `ALR_PORT_TIMER:     port_of = alr_pkg::ALR_TIMER;
      `ALR_PORT_TIMER_TWO: port_of = alr_pkg::ALR_TIMER_TWO;
      `ALR_PORT_RTC_INDEX: port_of = alr_pkg::ALR_RTC;
      default:             port_of = alr_pkg::ALR_NONE;
    endcase
  endfunction

  // Reserved bits never reach software; stored copies may hold junk
  function automatic logic [7:0] intc_fixed(input logic [2:0] w, input logic [7:0] d);
    case (w)
      3'h0:    intc_fixed = d & `ALR_INIT_TWO_KEEP;
      3'h2:    intc_fixed = d & `ALR_INIT_FOUR_KEEP;
      3'h4:    intc_fixed = d & `ALR_EOI_KEEP;
      3'h5:    intc_fixed = {1'b0, d[6], d[6], `ALR_POLL_FORCED, d[2:0]};
      default: intc_fixed = d;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Sequence positions
  // ---------------------------------------------------------------
  alr_seq_if sq ();

  alr_seq_ptr u_seq (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sq      (sq.seq)
  );

  alr_pkg::alr_port_t rd_port;
  alr_pkg::alr_port_t wr_port;
  logic               mode_q;
  logic               mode_rd;
  logic               mode_wr;

  assign rd_port  = port_of(io_addr);
  assign wr_port  = rd_port;
  assign mode_rd  = io_rd && mode_q && rd_port != alr_pkg::ALR_NONE;
  assign mode_wr  = io_wr && mode_q && wr_port != alr_pkg::ALR_NONE;
  assign sq.enter = alternate_access_mode && !mode_q;
  assign sq.rd    = {mode_rd && rd_port == alr_pkg::ALR_TIMER,
                     mode_rd && rd_port == alr_pkg::ALR_INTC};

  // ---------------------------------------------------------------
  // Readback data path
  // ---------------------------------------------------------------
  logic       ctl;
  logic [2:0] word;
  logic [7:0] rd_value;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       next_rwr;
  logic [7:0] next_rport;
  logic [7:0] next_rdat;

  assign ctl  = sq.ptr[0] >= 4'(`ALR_INTC_WORDS);
  assign word = ctl ? 3'(sq.ptr[0] - 4'(`ALR_INTC_WORDS)) : sq.ptr[0][2:0];

  always_comb begin
    rd_value = 8'h00;
    case (rd_port)
      alr_pkg::ALR_INTC: begin
        rd_value = intc_fixed(word, intc_words[ctl][word]);
      end
      alr_pkg::ALR_TIMER: begin
        case (sq.ptr[1])
          4'h0:    rd_value = timer_zero_status & `ALR_STATUS_KEEP;
          4'h1:    rd_value = timer_zero_base[7:0];
          4'h2:    rd_value = timer_zero_base[15:8];
          4'h5:    rd_value = timer_two_base[7:0];
          4'h6:    rd_value = timer_two_base[15:8];
          default: rd_value = 8'h00;
        endcase
      end
      alr_pkg::ALR_TIMER_TWO: rd_value = timer_two_status & `ALR_STATUS_KEEP;
      alr_pkg::ALR_RTC:       rd_value = {1'b0, rtc_index} & `ALR_RTC_KEEP;
      default:                rd_value = 8'h00;
    endcase
  end

  // Outside the mode this block stays silent and legacy decode answers
  always_comb begin
    next_rdata  = io_rdata;
    next_rvalid = mode_rd;
    next_rwr    = mode_wr;
    next_rport  = restore_port;
    next_rdat   = restore_data;
    if (mode_rd) begin
      next_rdata = rd_value;
    end
    if (mode_wr) begin
      next_rport = io_addr[7:0];
      next_rdat  = io_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q         <= 1'b0;
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
      restore_wr     <= 1'b0;
      restore_port   <= 8'h00;
      restore_data   <= 8'h00;
    end else begin
      mode_q         <= alternate_access_mode;
      io_rdata       <= next_rdata;
      io_rdata_valid <= next_rvalid;
      restore_wr     <= next_rwr;
      restore_port   <= next_rport;
      restore_data   <= next_rdat;
    end
  end

  // ---------------------------------------------------------------
  // System tick rate
  // ---------------------------------------------------------------
  // Timer reads in the mode disturb the divider, so the tick speeds up
  // after exit until software reprograms channel 0.
  logic          timer_seen;
  logic          next_seen;
  logic          next_fast;
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_cnt;
  logic [TW-1:0] tick_end;
  logic          next_tick;

  assign tick_end = timer_fast ? TW'(TICK_FAST_CYCLES - 1) : TW'(TICK_SLOW_CYCLES - 1);

  always_comb begin
    next_seen = timer_seen;
    next_fast = timer_fast;
    if (sq.enter) begin
      next_seen = 1'b0;
    end else if (mode_rd && (rd_port == alr_pkg::ALR_TIMER ||
                             rd_port == alr_pkg::ALR_TIMER_TWO)) begin
      next_seen = 1'b1;
    end
    if (mode_q && !alternate_access_mode && timer_seen) begin
      next_fast = 1'b1;
    end else if (io_wr && !mode_q && wr_port == alr_pkg::ALR_TIMER) begin
      next_fast = 1'b0;
    end
    next_tick = tick_cnt >= tick_end;
    next_cnt  = next_tick ? '0 : tick_cnt + TW'(1);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timer_seen <= 1'b0;
      timer_fast <= 1'b0;
      tick_cnt   <= '0;
      sys_tick   <= 1'b0;
    end else begin
      timer_seen <= next_seen;
      timer_fast <= next_fast;
      tick_cnt   <= next_cnt;
      sys_tick   <= next_tick;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // First controller read since entry: position still at the start
  sequence s_entry_intc_read;
    mode_rd ##0 (rd_port == alr_pkg::ALR_INTC && sq.ptr[0] == 4'h0);
  endsequence

  sequence s_timer_then_exit;
    (timer_seen && mode_q && alternate_access_mode) ##1
      (mode_q && !alternate_access_mode);
  endsequence

  AST_READ_ANSWERED: assert property (mode_rd |=> io_rdata_valid)
    else $error("mode read got no answer");
  AST_SILENT_NORMAL: assert property ((io_rd && !mode_q) |=> !io_rdata_valid)
    else $error("readback visible outside mode");
  AST_RESTORE_WRITE: assert property (mode_wr |=>
    restore_wr && restore_data == $past(io_wdata) && restore_port == $past(io_addr[7:0]))
    else $error("restore write lost");
  AST_FIRST_INTC_WORD: assert property (s_entry_intc_read |=>
    io_rdata == {$past(intc_words[0][0][7:3]), 3'b000})
    else $error("first read after entry not init word two");
  AST_POLL_FIXED: assert property ((mode_rd && rd_port == alr_pkg::ALR_INTC && word == 3'h5)
    |=> io_rdata[7] == 1'b0 && io_rdata[5] == io_rdata[6] && io_rdata[4:3] == 2'b01)
    else $error("poll word reserved bits wrong");
  AST_INIT_FOUR_FIXED: assert property ((mode_rd && rd_port == alr_pkg::ALR_INTC &&
    word == 3'h2) |=> (io_rdata & 8'hED) == 8'h00)
    else $error("init word four reserved bits wrong");
  AST_TIMER_TWO_STATUS: assert property ((mode_rd && rd_port == alr_pkg::ALR_TIMER_TWO)
    |=> io_rdata == {2'b00, $past(timer_two_status[5:0])})
    else $error("channel 2 status wrong");
  AST_TIMER_ZERO_STATUS: assert property ((mode_rd && rd_port == alr_pkg::ALR_TIMER &&
    sq.ptr[1] == 4'h0) |=> io_rdata[7:6] == 2'b00)
    else $error("channel 0 status upper bits set");
  AST_RTC_INDEX: assert property ((mode_rd && rd_port == alr_pkg::ALR_RTC)
    |=> io_rdata == {1'b0, $past(rtc_index)})
    else $error("rtc index readback wrong");
  AST_FAST_AFTER_EXIT: assert property (s_timer_then_exit |=> timer_fast)
    else $error("tick not fast after mode exit");

endmodule // alr_readback

`default_nettype wire

/* File: logic/alr_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface alr_seq_if;
  logic                   enter;
  logic [1:0]             rd;
  alr_pkg::alr_ptr_t [1:0] ptr;

  modport ctrl (output enter, output rd, input ptr);
  modport seq  (input enter, input rd, output ptr);
endinterface

`default_nettype wire

/* File: logic/alr_seq_ptr.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alr_map.svh"

module alr_seq_ptr (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Sequence control
  alr_seq_if.seq    sq
);

  localparam alr_pkg::alr_ptr_t LAST [2] = '{`ALR_INTC_LAST, `ALR_TIMER_LAST};

  // Unpacked so each generate branch owns its own element
  alr_pkg::alr_ptr_t       ptr      [2];
  alr_pkg::alr_ptr_t       next_ptr [2];

  assign sq.ptr = {ptr[1], ptr[0]};

  // ---------------------------------------------------------------
  // One position counter per multi-read port
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_comb begin
      next_ptr[i] = ptr[i];
      if (sq.enter) begin
        next_ptr[i] = '0;
      end else if (sq.rd[i] && ptr[i] != LAST[i]) begin
        next_ptr[i] = ptr[i] + 4'h1;
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        ptr[i] <= '0;
      end else begin
        ptr[i] <= next_ptr[i];
      end
    end

    AST_PTR_STEP: assert property (@(posedge clock) disable iff (sys_rst)
      (sq.rd[i] && !sq.enter && ptr[i] != LAST[i]) |=> ptr[i] == $past(ptr[i]) + 4'h1)
      else $error("sequence position did not advance");
    AST_PTR_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      (sq.rd[i] && !sq.enter && ptr[i] == LAST[i]) |=> $stable(ptr[i]))
      else $error("sequence position moved past last entry");
  end

endmodule // alr_seq_ptr

`default_nettype wire

/* File: test/alt_access_readback_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Compare macro
// ---------------------------------------------------------------
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end

module alt_access_readback_tb;
  localparam int FAST = 20;
  localparam int SLOW = 50;

  logic                 clock = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 alternate_access_mode = 1'b0;
  logic [15:0]          io_addr = 16'h0000;
  logic                 io_rd = 1'b0;
  logic                 io_wr = 1'b0;
  logic [7:0]           io_wdata = 8'h00;
  logic [7:0]           io_rdata;
  logic                 io_rdata_valid;
  logic                 restore_wr;
  logic [7:0]           restore_port;
  logic [7:0]           restore_data;
  logic [1:0][5:0][7:0] intc_words = '0;
  logic [7:0]           timer_zero_status = 8'hFF;
  logic [15:0]          timer_zero_base = 16'hBEEF;
  logic [7:0]           timer_two_status = 8'hC7;
  logic [15:0]          timer_two_base = 16'h1234;
  logic [6:0]           rtc_index = 7'h6A;
  logic                 timer_fast;
  logic                 sys_tick;
  int                   errors = 0;
  int                   check_count = 0;

  always #2 clock = ~clock;

  alr_readback #(.TICK_FAST_CYCLES(FAST), .TICK_SLOW_CYCLES(SLOW)) dut (
    .clock(clock), .sys_rst(sys_rst), .alternate_access_mode(alternate_access_mode),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .restore_wr(restore_wr),
    .restore_port(restore_port), .restore_data(restore_data), .intc_words(intc_words),
    .timer_zero_status(timer_zero_status), .timer_zero_base(timer_zero_base),
    .timer_two_status(timer_two_status), .timer_two_base(timer_two_base),
    .rtc_index(rtc_index), .timer_fast(timer_fast), .sys_tick(sys_tick));

  // Bit 6 differs between controllers so the poll word mirror is seen both ways
  function automatic logic [7:0] raw(input int c, input int w);
    logic [2:0] k;
    k = 3'(w);
    return (c == 1 ? 8'h3C : 8'hC3) ^ {2'b00, k, k};
  endfunction

  function automatic logic [7:0] fixed(input int w, input logic [7:0] v);
    case (w)
      0: return v & 8'hF8;
      2: return v & 8'h12;
      4: return v & 8'hE7;
      5: return {1'b0, v[6], v[6], 2'b01, v[2:0]};
      default: return v;
    endcase
  endfunction

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic v);
    @(posedge clock); #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clock); #1;
    io_rd = 1'b0;
    `CHK(io_rdata_valid, v)
    if (v)
      `CHK(io_rdata, e)
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic v);
    @(posedge clock); #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clock); #1;
    io_wr = 1'b0;
    `CHK(restore_wr, v)
    if (v) begin
      `CHK(restore_port, a[7:0])
      `CHK(restore_data, d)
    end
  endtask

  task automatic mode(input logic m);
    @(posedge clock); #1;
    alternate_access_mode = m;
    @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_outside();
    rd(16'h0020, 8'h00, 1'b0);
    wr(16'h0042, 8'h5A, 1'b0);
  endtask

  // Fourteen reads: twelve entries then saturation on the last
  task automatic t_intc();
    for (int i = 0; i < 14; i++) begin
      int n;
      n = (i > 11) ? 11 : i;
      rd(16'h0020, fixed(n % 6, raw(n / 6, n % 6)), 1'b1);
    end
  endtask

  task automatic t_timer();
    logic [7:0] e [8] = '{8'h3F, 8'hEF, 8'hBE, 8'h00, 8'h00, 8'h34, 8'h12, 8'h12};
    for (int i = 0; i < 8; i++)
      rd(16'h0040, e[i], 1'b1);
  endtask

  task automatic t_single();
    rd(16'h0042, 8'h07, 1'b1);
    rd(16'h0070, 8'h6A, 1'b1);
    rd(16'h0060, 8'h00, 1'b0);
  endtask

  task automatic t_restore();
    wr(16'h0020, 8'hA1, 1'b1);
    wr(16'h0040, 8'h5E, 1'b1);
    wr(16'h0042, 8'h0F, 1'b1);
    wr(16'h0070, 8'hF0, 1'b1);
  endtask

  // Second interval is timed so a partial first period does not matter
  task automatic t_period(input int exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clock); #1;
        n++;
        if (n > 4 * SLOW) begin
          errors++;
          summarize();
        end
      end while (sys_tick !== 1'b1);
    end
    `CHK(n, exp)
  endtask

  initial begin
    // Junk in reserved bits: software need not read them back
    for (int c = 0; c < 2; c++)
      for (int w = 0; w < 6; w++)
        intc_words[c][w] = raw(c, w);
    repeat (6) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_outside();
    // Mask words are known to the bench before entry
    mode(1'b1);
    t_intc();
    t_timer();
    t_single();
    t_restore();
    mode(1'b0);
    @(posedge clock); #1;
    `CHK(timer_fast, 1'b1)
    t_period(FAST);
    // Entry just before a suspend: no timer restore follows the reads
    mode(1'b1);
    rd(16'h0020, fixed(0, raw(0, 0)), 1'b1);
    rd(16'h0040, 8'h3F, 1'b1);
    mode(1'b0);
    // Firmware reprograms channel 0 to the slow period
    wr(16'h0040, 8'h34, 1'b0);
    @(posedge clock); #1;
    `CHK(timer_fast, 1'b0)
    t_period(SLOW);
    summarize();
  end
endmodule // alt_access_readback_tb

`default_nettype wire
